// >>> src/disc_rw_sector_controller.sv
// Sector read/write controller: host registers, sequencer and encoder.
`timescale 1ns/1ps
`default_nettype none
`include "disc_rw_map.svh"
module disc_rw_sector_controller #(
    parameter logic [8:0] LOCK_TICKS = 9'h040
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Host control port
    input wire logic [7:0] host_ctl_bus_in,
    output logic [7:0] host_ctl_bus_out,
    output logic host_ctl_bus_oe_out,
    input wire logic host_dir_line_in,
    input wire logic host_reg_select_in,
    input wire logic host_chip_select_n_in,
    output logic fault_irq_n_out,
    // Disc data port
    input wire logic [7:0] disc_byte_bus_in,
    output logic [7:0] disc_byte_bus_out,
    output logic disc_byte_bus_oe_out,
    output logic byte_strobe_out,
    output logic ecc_field_start_n_out,
    input wire logic sector_start_n_in,
    input wire logic write_inhibit_n_in,
    // Servo and read chain
    input wire logic write_clock_in,
    input wire logic servo_error_n_in,
    input wire logic read_clock_in,
    input wire logic read_data_in,
    input wire logic current_unsafe_in,
    input wire logic parity_error_in,
    // Read/write electronics
    output logic write_gate_n_out,
    output logic parity_check_enable_out,
    output logic read_enable_out,
    output logic write_data_out,
    output logic [3:0] head_select_out,
    output logic [1:0] cyl_high_out,
    output logic [1:0] rw_adjust_out,
    output logic [2:0] phase_a_out,
    output logic [2:0] phase_b_out
);
    disc_rw_pkg::ctl_state_type s, n;
    logic sos_rise;
    logic sos_fall;
    logic cs_rise;
    logic wtick;
    logic rtick;
    logic tick;
    logic enc_shift;
    logic enc_need;
    logic enc_empty;
    logic enc_bit;
    logic [7:0] end_faults;
    logic [9:0] frame_next;

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    assign sos_rise = sector_start_n_in && !s.sos_d;
    assign sos_fall = !sector_start_n_in && s.sos_d;
    assign cs_rise = host_chip_select_n_in && !s.cs_n_d;
    assign wtick = write_clock_in && !s.wclk_d;
    assign rtick = read_clock_in && !s.rclk_d;
    assign tick = s.rden ? rtick : wtick;
    assign enc_shift = tick && ((s.st == disc_rw_pkg::ST_SYNC)
        || (s.st == disc_rw_pkg::ST_WDATA));
    assign frame_next = {s.fshift[8:0], read_data_in};

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The read buffer follows chip select directly; data comes from a flop.
    assign host_ctl_bus_out = s.rd_data;
    assign host_ctl_bus_oe_out = !host_chip_select_n_in
        && !host_dir_line_in;
    assign fault_irq_n_out = s.irq_n;
    assign disc_byte_bus_out = s.dbyte;
    assign disc_byte_bus_oe_out = s.rd_drive;
    assign byte_strobe_out = s.strobe;
    assign ecc_field_start_n_out = s.sef_n;
    assign write_gate_n_out = s.wgate_n;
    assign parity_check_enable_out = s.op_par;
    assign read_enable_out = s.rden;
    assign write_data_out = s.wdata;
    assign head_select_out = s.addr[3:0];
    assign cyl_high_out = s.addr[5:4];
    assign rw_adjust_out = s.addr[7:6];
    assign phase_a_out = s.phase_a;
    assign phase_b_out = s.phase_b;

    vblock_encoder u_encoder (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .clear_in(s.enc_clr),
        .shift_in(enc_shift),
        .load_in(s.enc_load),
        .byte_in(s.enc_byte),
        .need_out(enc_need),
        .empty_out(enc_empty),
        .bit_out(enc_bit)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        end_faults = 8'h00;
        n = s;
        n.strobe = 1'b0;
        n.enc_load = 1'b0;
        n.enc_clr = 1'b0;
        n.wdata = 1'b0;
        n.cs_n_d = host_chip_select_n_in;
        n.sos_d = sector_start_n_in;
        n.wclk_d = write_clock_in;
        n.rclk_d = read_clock_in;
        n.inhib_d = write_inhibit_n_in;
        n.rd_data = host_reg_select_in ? s.addr : s.status;
        if (wtick) begin
            n.phase_a = {s.phase_a[1:0], s.phase_a[2]};
        end
        if (tick) begin
            n.phase_b = {s.phase_b[1:0], s.phase_b[2]};
        end
        if (cs_rise && host_dir_line_in) begin
            if (host_reg_select_in) begin
                n.addr = host_ctl_bus_in;
            end else begin
                n.cmd = host_ctl_bus_in;
                if (host_ctl_bus_in[`CMD_CLEAR_BIT]) begin
                    n.status = `STATUS_RESET;
                    n.irq_n = 1'b1;
                end
            end
        end
        if (s.in_field && (s.op_wr || s.op_rd)) begin
            if (current_unsafe_in) begin
                n.pend[`FLT_UNSAFE_BIT] = 1'b1;
            end
            if (s.op_par && parity_error_in) begin
                n.pend[`FLT_PARITY_BIT] = 1'b1;
            end
            if (s.op_srv && s.op_rd && !servo_error_n_in) begin
                n.pend[`FLT_SERVO_BIT] = 1'b1;
            end
        end
        unique case (s.st)
            disc_rw_pkg::ST_IDLE, disc_rw_pkg::ST_DONE: begin
            end
            disc_rw_pkg::ST_SYNC: begin
                if (enc_shift) begin
                    n.wdata = enc_bit;
                end
                if (s.bcount != `SYNC_BYTES) begin
                    if (enc_need && !s.enc_load) begin
                        n.enc_load = 1'b1;
                        n.enc_byte = 8'h00;
                        n.bcount = s.bcount + 9'h001;
                    end
                end else if (enc_empty && !s.enc_load) begin
                    n.st = disc_rw_pkg::ST_FRAME;
                    n.fshift = `FRAME_WORD;
                    n.nbits = 4'h0;
                end
            end
            disc_rw_pkg::ST_FRAME: begin
                if (tick) begin
                    n.wdata = s.fshift[9];
                    n.fshift = {s.fshift[8:0], 1'b0};
                    n.nbits = s.nbits + 4'h1;
                    if (s.nbits == `FRAME_LAST) begin
                        n.st = disc_rw_pkg::ST_WDATA;
                    end
                end
            end
            disc_rw_pkg::ST_WDATA: begin
                if (enc_shift) begin
                    n.wdata = enc_bit;
                end
                if (s.strobe) begin
                    n.scount = s.scount + 9'h001;
                    if ((s.scount < `SEF_INDEX)
                        || (s.scount >= `DUMMY_END)) begin
                        n.enc_load = 1'b1;
                        n.enc_byte = disc_byte_bus_in;
                    end
                end else if (enc_need && !s.enc_load
                    && (s.scount < `WRITE_STROBES)) begin
                    n.strobe = 1'b1;
                end
            end
            disc_rw_pkg::ST_LOCK: begin
                if (wtick) begin
                    if (s.bcount == LOCK_TICKS - 9'h001) begin
                        n.rden = 1'b1;
                        n.st = disc_rw_pkg::ST_SEARCH;
                        n.fshift = 10'h000;
                    end else begin
                        n.bcount = s.bcount + 9'h001;
                    end
                end
            end
            disc_rw_pkg::ST_SEARCH: begin
                if (rtick) begin
                    n.fshift = frame_next;
                    if (frame_next == `FRAME_WORD) begin
                        n.st = disc_rw_pkg::ST_RDATA;
                        n.nbits = 4'h0;
                    end
                end
            end
            disc_rw_pkg::ST_RDATA: begin
                if (s.strobe) begin
                    n.scount = s.scount + 9'h001;
                end
                if (rtick) begin
                    n.fshift = frame_next;
                    n.nbits = s.nbits + 4'h1;
                    if (s.nbits == 4'h7) begin
                        n.nbits = 4'h0;
                        if (s.scount < `READ_STROBES && !s.strobe) begin
                            n.dbyte = frame_next[7:0];
                            n.strobe = 1'b1;
                        end
                    end
                end
                if (n.scount == `READ_STROBES) begin
                    n.st = disc_rw_pkg::ST_DONE;
                end
            end
        endcase
        if (n.scount == `SEF_INDEX) begin
            n.sef_n = 1'b0;
        end
        if (sos_fall) begin
            n.in_field = 1'b1;
            n.scount = 9'h000;
            n.bcount = 9'h000;
            n.st = disc_rw_pkg::ST_IDLE;
            if (s.inhib_d && s.op_wr) begin
                n.st = disc_rw_pkg::ST_SYNC;
                n.wgate_n = 1'b0;
                n.enc_clr = 1'b1;
            end else if (s.inhib_d && s.op_rd) begin
                n.st = disc_rw_pkg::ST_LOCK;
                n.rd_drive = 1'b1;
            end
        end
        if (sos_rise) begin
            end_faults = n.pend;
            if (s.st == disc_rw_pkg::ST_SEARCH) begin
                end_faults[`FLT_NOFRAME_BIT] = 1'b1;
            end
            // A clear in this cycle is applied first so new faults survive.
            n.status = n.status | end_faults;
            if (end_faults != 8'h00) begin
                n.irq_n = 1'b0;
            end
            n.pend = 8'h00;
            n.op_wr = n.cmd[`CMD_WRITE_BIT];
            n.op_rd = n.cmd[`CMD_READ_BIT];
            n.op_par = n.cmd[`CMD_PARITY_BIT];
            n.op_srv = n.cmd[`CMD_SERVO_BIT];
            n.cmd[`CMD_WRITE_BIT] = 1'b0;
            n.cmd[`CMD_READ_BIT] = 1'b0;
            n.in_field = 1'b0;
            n.rd_drive = 1'b0;
            n.st = disc_rw_pkg::ST_IDLE;
            n.wgate_n = 1'b1;
            n.rden = 1'b0;
            n.sef_n = 1'b1;
            n.strobe = 1'b0;
        end
        if (s.in_field && s.op_wr && current_unsafe_in) begin
            n.wgate_n = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    localparam disc_rw_pkg::ctl_state_type CTL_RESET = '{
        st: disc_rw_pkg::ST_IDLE,
        addr: `ADDR_RESET,
        cmd: `CMD_RESET,
        status: `STATUS_RESET,
        cs_n_d: 1'b1,
        sos_d: 1'b1,
        inhib_d: 1'b1,
        irq_n: 1'b1,
        wgate_n: 1'b1,
        sef_n: 1'b1,
        phase_a: `PHASE_RESET,
        phase_b: `PHASE_RESET,
        default: '0
    };

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= CTL_RESET;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    sequence s_addr_write;
        $rose(host_chip_select_n_in) && host_dir_line_in && host_reg_select_in;
    endsequence
    property p_addr_write;
        s_addr_write |=> (head_select_out == $past(host_ctl_bus_in[3:0]));
    endproperty
    a_addr_write: assert property (p_addr_write)
        else $error("address not captured on chip select rise");

    property p_read_mux;
        !host_dir_line_in && host_reg_select_in && !host_chip_select_n_in
            |=> host_ctl_bus_out == $past(s.addr);
    endproperty
    a_read_mux: assert property (p_read_mux)
        else $error("address register not presented on read");

    property p_irq_end;
        $rose(sector_start_n_in) && (s.pend != 8'h00)
            |=> !fault_irq_n_out && (s.status != 8'h00);
    endproperty
    a_irq_end: assert property (p_irq_end)
        else $error("pending fault not reported at sector end");

    property p_bus_release;
        $rose(sector_start_n_in) |=> !disc_byte_bus_oe_out;
    endproperty
    a_bus_release: assert property (p_bus_release)
        else $error("disc bus still driven after sector end");

    property p_strobe_pulse;
        byte_strobe_out |=> !byte_strobe_out;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("byte strobe held longer than one cycle");

    property p_strobe_limit;
        byte_strobe_out |-> (s.op_rd && !s.op_wr) ?
            (s.scount < `READ_STROBES) : (s.scount < `WRITE_STROBES);
    endproperty
    a_strobe_limit: assert property (p_strobe_limit)
        else $error("too many strobes in one sector");

    property p_inhibit;
        $fell(sector_start_n_in) && !$past(write_inhibit_n_in)
            |=> write_gate_n_out && !disc_byte_bus_oe_out;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("sector operated despite inhibit");

    property p_op_copy;
        $rose(sector_start_n_in) && !cs_rise
            |=> (s.op_wr == $past(s.cmd[`CMD_WRITE_BIT]))
            && (parity_check_enable_out == $past(s.cmd[`CMD_PARITY_BIT]))
            && !s.cmd[`CMD_WRITE_BIT];
    endproperty
    a_op_copy: assert property (p_op_copy)
        else $error("command not copied at sector start rise");

    property p_unsafe_gate;
        s.in_field && s.op_wr && current_unsafe_in |=> write_gate_n_out;
    endproperty
    a_unsafe_gate: assert property (p_unsafe_gate)
        else $error("write gate not dropped on unsafe current");

    property p_frame_found;
        (s.st == disc_rw_pkg::ST_SEARCH) && rtick && !sos_rise
            && !sos_fall && (frame_next == `FRAME_WORD)
            |=> s.st == disc_rw_pkg::ST_RDATA;
    endproperty
    a_frame_found: assert property (p_frame_found)
        else $error("framing word seen but byte assembly not started");
endmodule : disc_rw_sector_controller
`default_nettype wire

// >>> inc/disc_rw_map.svh
// Register fields, fault positions, reset values and sector counts.
`ifndef DISC_RW_MAP_SVH
`define DISC_RW_MAP_SVH

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define CMD_WRITE_BIT 0
`define CMD_READ_BIT 1
`define CMD_CLEAR_BIT 3
`define CMD_PARITY_BIT 5
`define CMD_SERVO_BIT 6

// ----------------------------------------------------------------------
// Fault flag positions
// ----------------------------------------------------------------------
`define FLT_UNSAFE_BIT 0
`define FLT_PARITY_BIT 1
`define FLT_SERVO_BIT 2
`define FLT_NOFRAME_BIT 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADDR_RESET 8'h00
`define CMD_RESET 8'h00
`define STATUS_RESET 8'h00
`define PHASE_RESET 3'h1

// ----------------------------------------------------------------------
// Sector layout counts
// ----------------------------------------------------------------------
`define SYNC_BYTES 9'h00E
`define FRAME_WORD 10'h229
`define FRAME_LAST 4'h9
`define READ_STROBES 9'h114
`define WRITE_STROBES 9'h116
`define SEF_INDEX 9'h102
`define DUMMY_END 9'h104

`endif

// >>> inc/disc_rw_pkg.sv
// Types shared by the sector controller and its encoder.
package disc_rw_pkg;

    // ------------------------------------------------------------------
    // Sector sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_SYNC = 8'h02,
        ST_FRAME = 8'h04,
        ST_WDATA = 8'h08,
        ST_LOCK = 8'h10,
        ST_SEARCH = 8'h20,
        ST_RDATA = 8'h40,
        ST_DONE = 8'h80
    } sector_state_type;

    // ------------------------------------------------------------------
    // State records
    // ------------------------------------------------------------------
    typedef struct packed {
        sector_state_type st;
        logic [7:0] addr;
        logic [7:0] cmd;
        logic [7:0] status;
        logic [7:0] pend;
        logic op_wr;
        logic op_rd;
        logic op_par;
        logic op_srv;
        logic cs_n_d;
        logic sos_d;
        logic wclk_d;
        logic rclk_d;
        logic inhib_d;
        logic in_field;
        logic rd_drive;
        logic irq_n;
        logic wgate_n;
        logic rden;
        logic strobe;
        logic sef_n;
        logic wdata;
        logic enc_load;
        logic enc_clr;
        logic [7:0] enc_byte;
        logic [7:0] rd_data;
        logic [7:0] dbyte;
        logic [8:0] scount;
        logic [8:0] bcount;
        logic [9:0] fshift;
        logic [3:0] nbits;
        logic [2:0] phase_a;
        logic [2:0] phase_b;
    } ctl_state_type;

    typedef struct packed {
        logic [15:0] dsr;
        logic [4:0] dcnt;
        logic [5:0] csr;
        logic [2:0] ccnt;
    } enc_state_type;

endpackage : disc_rw_pkg

// >>> src/vblock_encoder.sv
// Variable block code encoder feeding the write data pulses.
`timescale 1ns/1ps
`default_nettype none
module vblock_encoder (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Control and data
    input wire logic clear_in,
    input wire logic shift_in,
    input wire logic load_in,
    input wire logic [7:0] byte_in,
    // Status and code bit
    output logic need_out,
    output logic empty_out,
    output logic bit_out
);
    disc_rw_pkg::enc_state_type s, n;

    assign need_out = (s.dcnt <= 5'h08);
    assign empty_out = (s.dcnt == 5'h00) && (s.ccnt == 3'h0);
    assign bit_out = s.csr[5];

    // ------------------------------------------------------------------
    // Block parser
    // ------------------------------------------------------------------
    // A pair 11 waits for two more bits, so a trailing 11 stalls until the
    // next byte arrives.
    always_comb begin
        n = s;
        if (shift_in && (s.ccnt != 3'h0)) begin
            n.csr = {s.csr[4:0], 1'b0};
            n.ccnt = s.ccnt - 3'h1;
        end
        if (s.ccnt == 3'h0) begin
            if ((s.dcnt >= 5'h02) && (s.dsr[15:14] != 2'b11)) begin
                case (s.dsr[15:14])
                    2'b00: n.csr = {~1'b0, 2'b01, 3'b000};
                    2'b01: n.csr = 6'b010000;
                    default: n.csr = {~1'b1, 2'b10, 3'b000};
                endcase
                n.ccnt = 3'h3;
                n.dsr = {s.dsr[13:0], 2'b00};
                n.dcnt = s.dcnt - 5'h02;
            end else if ((s.dcnt >= 5'h04) && (s.dsr[15:14] == 2'b11)) begin
                case (s.dsr[13:12])
                    2'b00: n.csr = 6'b010001;
                    2'b01: n.csr = {~1'b0, 5'b00000};
                    2'b10: n.csr = {~1'b0, 5'b00001};
                    default: n.csr = 6'b010000;
                endcase
                n.ccnt = 3'h6;
                n.dsr = {s.dsr[11:0], 4'h0};
                n.dcnt = s.dcnt - 5'h04;
            end
        end
        if (load_in) begin
            n.dsr = n.dsr | ({byte_in, 8'h00} >> n.dcnt);
            n.dcnt = n.dcnt + 5'h08;
        end
        if (clear_in) begin
            n = '0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    property p_enc_four;
        (s.ccnt == 3'h0) && (s.dcnt >= 5'h04) && (s.dsr[15:12] == 4'hD)
            && !clear_in |=> (s.ccnt == 3'h6) && (s.csr == 6'b100000);
    endproperty
    a_enc_four: assert property (p_enc_four)
        else $error("four bit block 1101 not coded as 100000");
endmodule : vblock_encoder
`default_nettype wire

// >>> dv/dma_model.sv
// Data engine stand-in on the disc byte bus.
`timescale 1ns/1ps
`default_nettype none
module dma_model (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic clr_in,
    input wire logic byte_strobe_in,
    input wire logic ecc_field_start_n_in,
    output logic [7:0] byte_out,
    output logic [8:0] count_out
);
    logic stb_d;
    // Bytes change only after a strobe fall, so the one in flight is held.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stb_d <= 1'b0;
            count_out <= 9'h000;
            byte_out <= 8'h00;
        end else begin
            stb_d <= byte_strobe_in;
            if (clr_in) count_out <= 9'h000;
            else if (byte_strobe_in && !stb_d) count_out <= count_out + 9'h001;
            if (stb_d && !byte_strobe_in) byte_out <= ecc_field_start_n_in ?
                count_out[7:0] : ~count_out[7:0];
        end
    end
endmodule : dma_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the sector controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_in = 1'b0, nrst_in = 1'b0, sos_n = 1'b1, inh_n = 1'b1;
    logic cs_n = 1'b1, dir = 1'b0, sel = 1'b0, perr = 1'b0, clr = 1'b0;
    logic [7:0] hin = 8'h00, hout, dd_in, dd_out, d;
    logic hoe, irq_n, doe, stb, sef_n, gate_n, pen, g_s, o_s, s_s, p_s;
    logic ren, wd, r_s, w_s, cur = 1'b0;
    logic [7:0] rb;
    logic [3:0] head;
    logic [3:0] ri = 4'h0;
    logic [1:0] cyl, adj;
    logic [1:0] ck = 2'h0;
    logic [8:0] nstb;
    int err_count = 0, checks = 0;
    localparam logic [9:0] FRAME = 10'h229;
    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        ck <= ck + 2'h1;
        if (ck == 2'h3) ri <= (ri == 4'h9) ? 4'h0 : ri + 4'h1;
        g_s <= !clr & (g_s | !gate_n);
        o_s <= !clr & (o_s | doe);
        s_s <= !clr & (s_s | !sef_n);
        p_s <= !clr & (p_s | pen);
        r_s <= !clr & (r_s | ren);
        w_s <= !clr & (w_s | wd);
        if (stb && doe && nstb == 9'h000) rb <= dd_out;
    end
    disc_rw_sector_controller #(.LOCK_TICKS(9'h004)) DUT (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .host_ctl_bus_in(hin), .host_ctl_bus_out(hout),
        .host_ctl_bus_oe_out(hoe), .host_dir_line_in(dir),
        .host_reg_select_in(sel), .host_chip_select_n_in(cs_n),
        .fault_irq_n_out(irq_n), .disc_byte_bus_in(dd_in),
        .disc_byte_bus_out(dd_out), .disc_byte_bus_oe_out(doe),
        .byte_strobe_out(stb), .ecc_field_start_n_out(sef_n),
        .sector_start_n_in(sos_n), .write_inhibit_n_in(inh_n),
        .write_clock_in(ck[1]), .servo_error_n_in(!perr),
        .read_clock_in(ck[1]), .read_data_in(FRAME[4'h9 - ri]),
        .current_unsafe_in(cur), .parity_error_in(perr),
        .write_gate_n_out(gate_n), .parity_check_enable_out(pen),
        .read_enable_out(ren), .write_data_out(wd), .head_select_out(head),
        .cyl_high_out(cyl), .rw_adjust_out(adj), .phase_a_out(),
        .phase_b_out());
    dma_model DMA (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .clr_in(clr), .byte_strobe_in(stb), .ecc_field_start_n_in(sef_n),
        .byte_out(dd_in), .count_out(nstb));
    task automatic chk(input string nm, input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic hw(input logic s, input logic [7:0] v);
        @(posedge clk_sys_in) {cs_n, dir, sel, hin} <= {2'b01, s, v};
        @(posedge clk_sys_in) cs_n <= 1'b1;
        repeat (2) @(posedge clk_sys_in) dir <= 1'b0;
    endtask : hw
    task automatic hr(input logic s);
        @(posedge clk_sys_in) {cs_n, dir, sel} <= {2'b00, s};
        @(posedge clk_sys_in) #1 chk("host oe", hoe, 1'b1);
        d = hout;
        @(posedge clk_sys_in) cs_n <= 1'b1;
        @(posedge clk_sys_in) #1 chk("host oe off", hoe, 1'b0);
    endtask : hr
    task automatic field(input logic [7:0] c, input logic inh,
        input logic [1:0] pe, input int n);
        @(posedge clk_sys_in) {inh_n, clr} <= {~inh, 1'b1};
        @(posedge clk_sys_in) clr <= 1'b0;
        @(posedge clk_sys_in) sos_n <= 1'b0;
        repeat (10) @(posedge clk_sys_in) inh_n <= 1'b1;
        // A zero byte goes to the address register, so the command is kept.
        hw(c == 8'h00, c);
        {cur, perr} <= pe;
        repeat (n) @(posedge clk_sys_in) {cur, perr} <= 2'b00;
        chk("irq in field", irq_n, 1'b1);
        sos_n <= 1'b1;
        repeat (30) @(posedge clk_sys_in);
    endtask : field
    initial begin
        repeat (8) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        hw(1'b1, 8'hB6);
        hr(1'b1);
        chk("address", d, 8'hB6);
        chk("address pins", {adj, cyl, head}, 8'hB6);
        hr(1'b0);
        chk("status", d, 8'h00);
        $display("test registers done");
        field(8'h01, 1'b0, 1'b0, 100);
        field(8'h00, 1'b0, 1'b0, 16000);
        chk("write strobes", nstb, 9'h116);
        chk("gate ecc data", {g_s, s_s, o_s, irq_n, w_s}, 5'h1B);
        field(8'h00, 1'b0, 1'b0, 2000);
        chk("idle sector", {nstb, g_s}, 10'h000);
        $display("test write done");
        field(8'h62, 1'b0, 1'b0, 100);
        field(8'h00, 1'b0, 1'b1, 16000);
        chk("read strobes", nstb, 9'h114);
        chk("oe parity gate irq", {o_s, p_s, g_s, irq_n, r_s}, 5'h19);
        chk("read byte", rb, 8'h8A);
        hr(1'b0);
        chk("parity servo flags", d, 8'h06);
        field(8'h08, 1'b0, 1'b0, 100);
        hr(1'b0);
        chk("cleared", {irq_n, d}, 9'h100);
        $display("test read done");
        field(8'h01, 1'b0, 1'b0, 100);
        field(8'h01, 1'b1, 1'b0, 2000);
        chk("inhibited", {nstb, g_s}, 10'h000);
        $display("test inhibit done");
        field(8'h00, 1'b0, 2'b10, 2000);
        hr(1'b0);
        chk("unsafe flag", {irq_n, g_s, d}, 10'h101);
        $display("test unsafe done");
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        err_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
